// file: rtl/psb_pkg.sv
package psb_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [4:0]  REG_WINDOW      = 5'h0e;
    localparam logic [4:0]  REG_ABILITY     = 5'h0f;
    localparam logic [4:0]  REG_FE_STATUS   = 5'h10;
    localparam logic [4:0]  REG_GIG_STATUS  = 5'h11;
    localparam logic [4:0]  REG_BYPASS      = 5'h12;
    localparam logic [4:0]  REG_RX_ERR_CNT  = 5'h13;
    localparam logic [4:0]  REG_FALSE_CNT   = 5'h14;

    // ----------------------------------------------------------------
    // Window function codes
    // ----------------------------------------------------------------
    localparam logic [1:0]  FUNC_ADDR       = 2'h0;
    localparam logic [1:0]  FUNC_DATA       = 2'h1;
    localparam logic [1:0]  FUNC_INC_RW     = 2'h2;
    localparam logic [1:0]  FUNC_INC_W      = 2'h3;

    // ----------------------------------------------------------------
    // Fixed values, defaults and masks
    // ----------------------------------------------------------------
    localparam logic [15:0] ABILITY_VALUE   = 16'h3000;
    localparam logic [15:0] BYP_DEFAULT     = 16'h0088;
    localparam logic [15:0] BYP_WR_MASK     = 16'hfefe;
    localparam logic [15:0] BYP_STICKY_MASK = 16'h00fa;
    localparam logic [7:0]  CNT_MAX         = 8'hff;
    localparam logic [7:0]  CNT_ZERO        = 8'h00;
    localparam logic [7:0]  LOW_BYTE_ZERO   = 8'h00;
    localparam logic [4:0]  GIG_RSVD_ZERO   = 5'h00;
    localparam logic [15:0] WORD_ZERO       = 16'h0000;

    // ----------------------------------------------------------------
    // Bypass control bit positions
    // ----------------------------------------------------------------
    localparam int BYP_TX_DISABLE   = 15;
    localparam int BYP_ENC_4B5B     = 14;
    localparam int BYP_SCRAMBLER    = 13;
    localparam int BYP_DESCRAMBLER  = 12;
    localparam int BYP_PCS_RX       = 11;
    localparam int BYP_PCS_TX       = 10;
    localparam int BYP_LFI_TIMER    = 9;
    localparam int BYP_XOVER_FORCED = 7;
    localparam int BYP_LEGACY_DIS   = 6;
    localparam int BYP_PAIR_SWAP    = 5;
    localparam int BYP_POLARITY     = 4;
    localparam int BYP_PAR_DETECT   = 3;
    localparam int BYP_PULSE_SHAPE  = 2;
    localparam int BYP_NEXT_PAGE    = 1;

    // ----------------------------------------------------------------
    // Management frame fields
    // ----------------------------------------------------------------
    localparam logic [5:0]  PRE_LEN         = 6'd32;
    localparam logic [5:0]  HDR_LAST        = 6'd13;
    localparam logic [5:0]  DATA_LAST       = 6'd15;
    localparam logic [5:0]  TA_FIRST        = 6'd0;
    localparam logic [5:0]  TA_LAST         = 6'd1;
    localparam logic [1:0]  START_CODE      = 2'b01;
    localparam logic [1:0]  OP_READ         = 2'b10;
    localparam logic [1:0]  OP_WRITE        = 2'b01;

    typedef enum logic [2:0] {
        PSB_PRE  = 3'b000,
        PSB_HDR  = 3'b001,
        PSB_TA   = 3'b010,
        PSB_RD   = 3'b011,
        PSB_WR   = 3'b100
    } psb_state_t;
endpackage

// file: rtl/psb_regs.sv
// Notes on behaviour
// [RULE1] Address function: window sets clause 45 register address
// [RULE2] Data functions: window reads or writes addressed register
// [RULE3] Function code picks address, data, increment variants
// [RULE4] Ability register read-only: fixed 0x3000 pattern
// [RULE5] Fast status shows live lock and link
// [RULE6] Fast status error flags clear when read
// [RULE7] Gigabit status shows live lock and link
// [RULE8] Gigabit status error flags clear when read
// [RULE9] Carrier extension error flag clears when read
// [RULE10] Legacy partner and crossover error shown live
// [RULE11] Bypass bit 15 disables line transmitter
// [RULE12] Bits 14..12 bypass encoder, scrambler, descrambler
// [RULE13] Bits 11, 10 bypass PCS receive, transmit
// [RULE14] Bit 9 bypasses link fail inhibit timer
// [RULE15] Sticky bit 7 disables crossover at forced speed
// [RULE16] Sticky bit 6 disables legacy partner detection
// [RULE17] Sticky bits 5, 4 disable swap, polarity correction
// [RULE18] Sticky bit 3 parallel detect honours advertisement
// [RULE19] Bit 2 disables transmit pulse shaping filter
// [RULE20] Sticky bit 1 hands next pages to host
// [RULE21] Host then runs next pages and forces config
// [RULE22] Receive error counter saturates, clears on read
// [RULE23] False carrier counter saturates, clears on read
// [RULE24] Sticky bits survive soft reset when enabled
// [RULE25] Flags latch; new event beats read clear
// [RULE26] Reserved bits read zero, ignore writes
module psb_regs (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe,
    input  wire logic [4:0]  phy_addr,
    input  wire logic        soft_reset,
    input  wire logic        sticky_reset_en,
    input  wire logic [1:0]  c45_function,
    input  wire logic [4:0]  clause45_device_select,
    input  wire logic [15:0] c45_rdata,
    output logic [15:0]      c45_addr,
    output logic [4:0]       c45_device,
    output logic [15:0]      c45_wdata,
    output logic             c45_wr,
    output logic             c45_rd,
    input  wire logic        fe_descr_lock,
    input  wire logic        fe_link,
    input  wire logic [5:0]  fe_err_evt,
    input  wire logic        gig_descr_lock,
    input  wire logic        gig_link,
    input  wire logic [5:0]  gig_err_evt,
    input  wire logic        carrier_ext_evt,
    input  wire logic        legacy_partner_seen,
    input  wire logic        mdi_xover_err,
    input  wire logic        forced_10_100,
    input  wire logic        rx_err_evt,
    input  wire logic        false_carrier_evt,
    output logic             tx_disable,
    output logic             bypass_4b5b,
    output logic             bypass_scrambler,
    output logic             bypass_descrambler,
    output logic             bypass_pcs_rx,
    output logic             bypass_pcs_tx,
    output logic             bypass_link_fail_inhibit_timer,
    output logic             auto_crossover_disable,
    output logic             pair_swap_disable,
    output logic             polarity_corr_disable,
    output logic             parallel_detect_honour,
    output logic             pulse_shape_disable,
    output logic             manual_next_page,
    output logic             legacy_detect_enable
);
    import psb_pkg::*;

    // ----------------
    // Pin synchronisers
    // ----------------
    logic mdc_s1, mdc_s2, mdc_s3;
    logic mdio_s1, mdio_s2;
    logic mdc_rise;
    logic bit_in;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mdc_s1  <= 1'b0;
            mdc_s2  <= 1'b0;
            mdc_s3  <= 1'b0;
            mdio_s1 <= 1'b1;
            mdio_s2 <= 1'b1;
        end else begin
            mdc_s1  <= mdc;
            mdc_s2  <= mdc_s1;
            mdc_s3  <= mdc_s2;
            mdio_s1 <= mdio_in;
            mdio_s2 <= mdio_s1;
        end
    end

    assign mdc_rise = mdc_s2 & ~mdc_s3;
    assign bit_in   = mdio_s2;

    // ----------------
    // Register state
    // ----------------
    psb_state_t  state;
    logic [5:0]  bcnt;
    logic [15:0] shreg;
    logic [15:0] rd_shift;
    logic [15:0] wr_data;
    logic [4:0]  regad;
    logic        is_read;
    logic        rd_take;
    logic        wr_go;
    logic        hdr_rd_req;
    logic        inc_pend;
    logic [15:0] bypass;
    logic [5:0]  fe_flags;
    logic [6:0]  gig_flags;
    logic [7:0]  rx_err_cnt;
    logic [7:0]  false_cnt;
    logic [15:0] rd_word;
    logic [13:0] hdr;
    logic        hdr_ok;
    logic        clr_fe, clr_gig, clr_rx, clr_fc;

    assign hdr    = {shreg[12:0], bit_in};
    assign hdr_ok = (hdr[13:12] == START_CODE) && (hdr[9:5] == phy_addr)
                    && ((hdr[11:10] == OP_READ) || (hdr[11:10] == OP_WRITE));
    assign clr_fe  = rd_take && (regad == REG_FE_STATUS);
    assign clr_gig = rd_take && (regad == REG_GIG_STATUS);
    assign clr_rx  = rd_take && (regad == REG_RX_ERR_CNT);
    assign clr_fc  = rd_take && (regad == REG_FALSE_CNT);

    // ----------------
    // Read data select
    // ----------------
    always_comb begin
        case (regad)
            REG_WINDOW:     rd_word = (c45_function == FUNC_ADDR) ? c45_addr : c45_rdata; // [RULE1] [RULE2]
            REG_ABILITY:    rd_word = ABILITY_VALUE; // [RULE4]
            REG_FE_STATUS:  rd_word = {fe_descr_lock, fe_flags[5:4], fe_link, fe_flags[3:0], LOW_BYTE_ZERO}; // [RULE5]
            REG_GIG_STATUS: rd_word = {gig_descr_lock, gig_flags[6:5], gig_link, gig_flags[4:0], // [RULE7]
                                       legacy_partner_seen & legacy_detect_enable, mdi_xover_err, // [RULE10]
                                       GIG_RSVD_ZERO};
            REG_BYPASS:     rd_word = bypass & BYP_WR_MASK; // [RULE26]
            REG_RX_ERR_CNT: rd_word = {LOW_BYTE_ZERO, rx_err_cnt}; // [RULE22]
            REG_FALSE_CNT:  rd_word = {LOW_BYTE_ZERO, false_cnt}; // [RULE23]
            default:        rd_word = WORD_ZERO;
        endcase
    end

    // ----------------
    // Management frame engine
    // ----------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= PSB_PRE;
            bcnt       <= 6'd0;
            shreg      <= WORD_ZERO;
            rd_shift   <= WORD_ZERO;
            wr_data    <= WORD_ZERO;
            regad      <= 5'h00;
            is_read    <= 1'b0;
            rd_take    <= 1'b0;
            wr_go      <= 1'b0;
            hdr_rd_req <= 1'b0;
            mdio_out   <= 1'b0;
            mdio_oe    <= 1'b0;
        end else begin
            rd_take    <= 1'b0;
            wr_go      <= 1'b0;
            hdr_rd_req <= 1'b0;
            if (mdc_rise) begin
                case (state)
                    PSB_PRE: begin
                        if (bit_in) begin
                            if (bcnt != PRE_LEN) begin
                                bcnt <= bcnt + 6'd1;
                            end
                        end else if (bcnt == PRE_LEN) begin
                            state <= PSB_HDR;
                            bcnt  <= 6'd1;
                            shreg <= WORD_ZERO;
                        end else begin
                            bcnt <= 6'd0;
                        end
                    end
                    PSB_HDR: begin
                        shreg <= {shreg[14:0], bit_in};
                        bcnt  <= bcnt + 6'd1;
                        if (bcnt == HDR_LAST) begin
                            bcnt    <= 6'd0;
                            regad   <= hdr[4:0];
                            is_read <= (hdr[11:10] == OP_READ);
                            state   <= hdr_ok ? PSB_TA : PSB_PRE;
                            hdr_rd_req <= hdr_ok && (hdr[11:10] == OP_READ)
                                          && (hdr[4:0] == REG_WINDOW) && (c45_function != FUNC_ADDR); // [RULE2]
                        end
                    end
                    PSB_TA: begin
                        bcnt <= bcnt + 6'd1;
                        if (bcnt == TA_FIRST && is_read) begin
                            rd_take  <= 1'b1;
                            rd_shift <= rd_word;
                            mdio_oe  <= 1'b1;
                            mdio_out <= 1'b0;
                        end
                        if (bcnt == TA_LAST) begin
                            bcnt  <= 6'd0;
                            state <= is_read ? PSB_RD : PSB_WR;
                            if (is_read) begin
                                mdio_out <= rd_shift[15];
                                rd_shift <= {rd_shift[14:0], 1'b0};
                            end
                        end
                    end
                    PSB_RD: begin
                        if (bcnt == DATA_LAST) begin
                            mdio_oe  <= 1'b0;
                            mdio_out <= 1'b0;
                            bcnt     <= 6'd0;
                            state    <= PSB_PRE;
                        end else begin
                            mdio_out <= rd_shift[15];
                            rd_shift <= {rd_shift[14:0], 1'b0};
                            bcnt     <= bcnt + 6'd1;
                        end
                    end
                    PSB_WR: begin
                        shreg <= {shreg[14:0], bit_in};
                        bcnt  <= bcnt + 6'd1;
                        if (bcnt == DATA_LAST) begin
                            wr_data <= {shreg[14:0], bit_in};
                            wr_go   <= 1'b1;
                            bcnt    <= 6'd0;
                            state   <= PSB_PRE;
                        end
                    end
                    default: begin
                        state <= PSB_PRE;
                        bcnt  <= 6'd0;
                    end
                endcase
            end
        end
    end

    // ----------------
    // Clause 45 window
    // ----------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            c45_addr   <= WORD_ZERO;
            c45_device <= 5'h00;
            c45_wdata  <= WORD_ZERO;
            c45_wr     <= 1'b0;
            c45_rd     <= 1'b0;
            inc_pend   <= 1'b0;
        end else begin
            c45_wr     <= 1'b0;
            c45_rd     <= hdr_rd_req; // [RULE2]
            c45_device <= clause45_device_select; // [RULE1]
            inc_pend   <= 1'b0;
            if (soft_reset) begin
                c45_addr <= WORD_ZERO;
            end else if (inc_pend) begin
                c45_addr <= c45_addr + 16'h0001; // [RULE3]
            end else if (wr_go && regad == REG_WINDOW) begin
                if (c45_function == FUNC_ADDR) begin
                    c45_addr <= wr_data; // [RULE1]
                end else begin
                    c45_wdata <= wr_data; // [RULE2]
                    c45_wr    <= 1'b1;
                    inc_pend  <= (c45_function == FUNC_INC_RW) || (c45_function == FUNC_INC_W); // [RULE3]
                end
            end else if (rd_take && regad == REG_WINDOW) begin
                inc_pend <= (c45_function == FUNC_INC_RW); // [RULE3]
            end
        end
    end

    // ----------------
    // Bypass control register
    // ----------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bypass <= BYP_DEFAULT;
        end else if (soft_reset) begin
            if (sticky_reset_en) begin
                bypass <= (bypass & BYP_STICKY_MASK) | (BYP_DEFAULT & ~BYP_STICKY_MASK); // [RULE24]
            end else begin
                bypass <= BYP_DEFAULT; // [RULE24]
            end
        end else if (wr_go && regad == REG_BYPASS) begin
            bypass <= wr_data & BYP_WR_MASK; // [RULE26]
        end
    end

    assign tx_disable                     = bypass[BYP_TX_DISABLE]; // [RULE11]
    assign bypass_4b5b                    = bypass[BYP_ENC_4B5B]; // [RULE12]
    assign bypass_scrambler               = bypass[BYP_SCRAMBLER]; // [RULE12]
    assign bypass_descrambler             = bypass[BYP_DESCRAMBLER]; // [RULE12]
    assign bypass_pcs_rx                  = bypass[BYP_PCS_RX]; // [RULE13]
    assign bypass_pcs_tx                  = bypass[BYP_PCS_TX]; // [RULE13]
    assign bypass_link_fail_inhibit_timer = bypass[BYP_LFI_TIMER]; // [RULE14]
    assign pair_swap_disable              = bypass[BYP_PAIR_SWAP]; // [RULE17]
    assign polarity_corr_disable          = bypass[BYP_POLARITY]; // [RULE17]
    assign parallel_detect_honour         = bypass[BYP_PAR_DETECT]; // [RULE18]
    assign pulse_shape_disable            = bypass[BYP_PULSE_SHAPE]; // [RULE19]
    assign manual_next_page               = bypass[BYP_NEXT_PAGE]; // [RULE20]

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_crossover_disable <= 1'b0;
            legacy_detect_enable   <= 1'b1;
        end else begin
            auto_crossover_disable <= bypass[BYP_XOVER_FORCED] & forced_10_100; // [RULE15]
            legacy_detect_enable   <= ~bypass[BYP_LEGACY_DIS]; // [RULE16]
        end
    end

    // ----------------------------------------------------------------
    // Self-clearing status flags
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fe_flags <= 6'h00;
        end else if (soft_reset) begin
            fe_flags <= 6'h00;
        end else begin
            fe_flags <= (fe_flags & ~{6{clr_fe}}) | fe_err_evt; // [RULE6] [RULE25]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gig_flags <= 7'h00;
        end else if (soft_reset) begin
            gig_flags <= 7'h00;
        end else begin
            gig_flags <= (gig_flags & ~{7{clr_gig}}) | {gig_err_evt, carrier_ext_evt}; // [RULE8] [RULE9] [RULE25]
        end
    end

    // ----------------------------------------------------------------
    // Saturating error counters
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_err_cnt <= CNT_ZERO;
        end else if (soft_reset) begin
            rx_err_cnt <= CNT_ZERO;
        end else if (clr_rx) begin
            rx_err_cnt <= rx_err_evt ? 8'h01 : CNT_ZERO; // [RULE22] [RULE25]
        end else if (rx_err_evt && rx_err_cnt != CNT_MAX) begin
            rx_err_cnt <= rx_err_cnt + 8'h01; // [RULE22]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            false_cnt <= CNT_ZERO;
        end else if (soft_reset) begin
            false_cnt <= CNT_ZERO;
        end else if (clr_fc) begin
            false_cnt <= false_carrier_evt ? 8'h01 : CNT_ZERO; // [RULE23] [RULE25]
        end else if (false_carrier_evt && false_cnt != CNT_MAX) begin
            false_cnt <= false_cnt + 8'h01; // [RULE23]
        end
    end
endmodule

// file: tb/psb_regs_chk.sv
// ----------
// Port checker
// ----------
module psb_regs_chk (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        mdio_out,
    input wire logic        mdio_oe,
    input wire logic        soft_reset,
    input wire logic        sticky_reset_en,
    input wire logic [1:0]  c45_function,
    input wire logic [15:0] c45_addr,
    input wire logic        c45_wr,
    input wire logic        c45_rd,
    input wire logic        forced_10_100,
    input wire logic        auto_crossover_disable,
    input wire logic        tx_disable,
    input wire logic        bypass_pcs_tx,
    input wire logic        pulse_shape_disable,
    input wire logic        parallel_detect_honour,
    input wire logic        pair_swap_disable
);
    import psb_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    AST_WR_FUNC: assert property (c45_wr |-> c45_function != FUNC_ADDR)
        else $error("data write in address mode");
    AST_WR_PULSE: assert property (c45_wr |=> !c45_wr)
        else $error("write strobe too long");
    AST_RD_PULSE: assert property (c45_rd |=> !c45_rd)
        else $error("read strobe too long");
    AST_ADDR_HOLD: assert property (c45_wr && c45_function == FUNC_DATA && !soft_reset |=> $stable(c45_addr) [*2])
        else $error("address moved");
    AST_ADDR_INC: assert property (c45_wr && c45_function == FUNC_INC_W && !soft_reset
        |=> c45_addr == $past(c45_addr) + 16'h0001)
        else $error("address not incremented");
    AST_OE_TA: assert property ($rose(mdio_oe) |-> (mdio_oe && !mdio_out) [*6])
        else $error("turnaround bit wrong");
    AST_SOFT_NS: assert property (soft_reset |-> ##[1:2] !(tx_disable | bypass_pcs_tx | pulse_shape_disable))
        else $error("plain bits kept");
    AST_STICKY_KEEP: assert property (soft_reset && sticky_reset_en |=> $stable(pair_swap_disable) [*2])
        else $error("sticky bit lost");
    AST_STICKY_DEF: assert property (soft_reset && !sticky_reset_en |-> ##[1:2] parallel_detect_honour)
        else $error("sticky default wrong");
    AST_XOVER: assert property (!forced_10_100 |=> !auto_crossover_disable)
        else $error("crossover off");
    cover property (c45_wr);
    cover property (c45_rd);
    cover property ($rose(mdio_oe));
endmodule
bind psb_regs psb_regs_chk u_psb_regs_chk (.ref_clk, .rst_n, .mdio_out, .mdio_oe, .soft_reset, .sticky_reset_en,
    .c45_function, .c45_addr, .c45_wr, .c45_rd, .forced_10_100, .auto_crossover_disable, .tx_disable,
    .bypass_pcs_tx, .pulse_shape_disable, .parallel_detect_honour, .pair_swap_disable);

// file: tb/psb_host.sv
// ----------
// Management host station
// ----------
module psb_host #(
    parameter logic [4:0] PHY = 5'h03
) (
    output logic            mdc,
    output logic            mdio_in,
    input wire logic        mdio_out,
    input wire logic        mdio_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    import psb_pkg::*;
    logic host_oe  = 1'b0;
    logic host_bit = 1'b1;
    // Pulled-up shared line
    assign mdio_in = host_oe ? host_bit : (mdio_oe ? mdio_out : 1'b1);
    initial mdc = 1'b0;
    task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [63:0] bits;
        bits = {32'hffffffff, START_CODE, op, PHY, ra, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            host_oe = (op == OP_WRITE) || (i > 17);
            host_bit = bits[i];
            #160;
            mdc = 1'b1;
            if (i < 16) rd[i] = mdio_in;
            #160;
            mdc = 1'b0;
        end
        host_oe = 1'b0;
    endtask
endmodule

// file: tb/psb_regs_tb.sv
// ----------
// Bench top
// ----------
module psb_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import psb_pkg::*;
    logic        ref_clk, rst_n, mdc, mdio_in, mdio_out, mdio_oe, soft_reset, sticky_reset_en, c45_wr, c45_rd;
    logic        fe_descr_lock, fe_link, gig_descr_lock, gig_link, carrier_ext_evt, legacy_partner_seen;
    logic        mdi_xover_err, forced_10_100, rx_err_evt, false_carrier_evt;
    logic        auto_crossover_disable, legacy_detect_enable;
    logic [1:0]  c45_function;
    logic [4:0]  clause45_device_select, c45_device;
    logic [5:0]  fe_err_evt, gig_err_evt;
    logic [11:0] byp;
    logic [15:0] c45_rdata, c45_addr, c45_wdata, rd;
    int          n_errors = 0;
    int          num_checks = 0;
    psb_regs u_psb_regs (.ref_clk, .rst_n, .mdc, .mdio_in, .mdio_out, .mdio_oe, .phy_addr(5'h03), .soft_reset,
        .sticky_reset_en, .c45_function, .clause45_device_select, .c45_rdata, .c45_addr, .c45_device, .c45_wdata,
        .c45_wr, .c45_rd, .fe_descr_lock, .fe_link, .fe_err_evt, .gig_descr_lock, .gig_link, .gig_err_evt,
        .carrier_ext_evt, .legacy_partner_seen, .mdi_xover_err, .forced_10_100, .rx_err_evt, .false_carrier_evt,
        .tx_disable(byp[11]), .bypass_4b5b(byp[10]), .bypass_scrambler(byp[9]), .bypass_descrambler(byp[8]),
        .bypass_pcs_rx(byp[7]), .bypass_pcs_tx(byp[6]), .bypass_link_fail_inhibit_timer(byp[5]),
        .pair_swap_disable(byp[4]), .polarity_corr_disable(byp[3]), .parallel_detect_honour(byp[2]),
        .pulse_shape_disable(byp[1]), .manual_next_page(byp[0]), .auto_crossover_disable, .legacy_detect_enable);
    psb_host u_psb_host (.mdc, .mdio_in, .mdio_out, .mdio_oe);
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic rreg(input logic [4:0] ra, input logic [15:0] exp, input string nm);
        u_psb_host.frame(OP_READ, ra, 16'h0000, rd);
        chk(nm, rd, exp);
    endtask
    task automatic wreg(input logic [4:0] ra, input logic [15:0] d);
        u_psb_host.frame(OP_WRITE, ra, d, rd);
    endtask
    task automatic sreset(input logic en);
        tick(1);
        sticky_reset_en = en;
        soft_reset = 1'b1;
        tick(1);
        soft_reset = 1'b0;
    endtask
    task automatic t_reset;
        wreg(REG_ABILITY, 16'hffff);
        rreg(REG_ABILITY, 16'h3000, "ability");
        rreg(REG_BYPASS, 16'h0088, "bypass");
        rreg(REG_RX_ERR_CNT, 16'h0000, "rxcnt");
        rreg(5'h1f, 16'h0000, "unmapped");
        $display("reset test done");
    endtask
    task automatic t_bypass;
        wreg(REG_BYPASS, 16'hffff);
        rreg(REG_BYPASS, 16'hfefe, "bypass");
        chk("byp_out", {4'h0, byp}, 16'h0fff);
        chk("legacy_en", {15'h0, legacy_detect_enable}, 16'h0000);
        tick(1);
        forced_10_100 = 1'b1;
        tick(2);
        chk("xover", {15'h0, auto_crossover_disable}, 16'h0001);
        sreset(1'b1);
        rreg(REG_BYPASS, 16'h00fa, "sticky");
        chk("byp_out", {4'h0, byp}, 16'h001d);
        sreset(1'b0);
        rreg(REG_BYPASS, 16'h0088, "default");
        forced_10_100 = 1'b0;
        $display("bypass test done");
    endtask
    task automatic t_status;
        tick(1);
        {fe_descr_lock, fe_link, gig_descr_lock, legacy_partner_seen, mdi_xover_err} = 5'h1f;
        {fe_err_evt, gig_err_evt, carrier_ext_evt} = {6'h3f, 6'h21, 1'b1};
        tick(1);
        {fe_err_evt, gig_err_evt, carrier_ext_evt} = '0;
        rreg(REG_FE_STATUS, 16'hff00, "fe");
        rreg(REG_FE_STATUS, 16'h9000, "fe_clr");
        rreg(REG_GIG_STATUS, 16'hc1e0, "gig");
        rreg(REG_GIG_STATUS, 16'h8060, "gig_clr");
        $display("status test done");
    endtask
    task automatic t_counters;
        for (int i = 0; i < 300; i++) begin
            tick(1);
            false_carrier_evt = 1'b1;
            rx_err_evt = (i < 3);
            tick(1);
            {false_carrier_evt, rx_err_evt} = 2'b00;
        end
        rreg(REG_RX_ERR_CNT, 16'h0003, "rxcnt");
        rreg(REG_RX_ERR_CNT, 16'h0000, "rxcnt_clr");
        rreg(REG_FALSE_CNT, 16'h00ff, "fccnt");
        rreg(REG_FALSE_CNT, 16'h0000, "fccnt_clr");
        $display("counter test done");
    endtask
    task automatic t_window;
        tick(1);
        c45_function = FUNC_ADDR;
        clause45_device_select = 5'h07;
        wreg(REG_WINDOW, 16'h0010);
        chk("addr", c45_addr, 16'h0010);
        chk("dev", {11'h0, c45_device}, 16'h0007);
        tick(1);
        c45_function = FUNC_DATA;
        wreg(REG_WINDOW, 16'h1111);
        chk("wdata", c45_wdata, 16'h1111);
        chk("addr", c45_addr, 16'h0010);
        tick(1);
        c45_function = FUNC_INC_W;
        wreg(REG_WINDOW, 16'hbeef);
        tick(1);
        chk("addr", c45_addr, 16'h0011);
        tick(1);
        c45_function = FUNC_INC_RW;
        c45_rdata = 16'h1234;
        rreg(REG_WINDOW, 16'h1234, "rdata");
        chk("addr", c45_addr, 16'h0012);
        $display("window test done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #1000000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        {rst_n, soft_reset, sticky_reset_en, c45_function, clause45_device_select, c45_rdata, fe_descr_lock, fe_link,
         fe_err_evt, gig_descr_lock, gig_link, gig_err_evt, carrier_ext_evt, legacy_partner_seen, mdi_xover_err,
         forced_10_100, rx_err_evt, false_carrier_evt} = '0;
        tick(4);
        rst_n = 1'b1;
        tick(10);
        t_reset();
        t_bypass();
        t_status();
        t_counters();
        t_window();
        report_and_stop();
    end
endmodule
